/* inc/upc_defines.vh */
`ifndef UPC_DEFINES_VH
`define UPC_DEFINES_VH

// ==================================================================
// Transceiver select codes
`define UPC_XCVR_HS        2'h0
`define UPC_XCVR_FS        2'h1
`define UPC_XCVR_LS        2'h2
`define UPC_XCVR_LS_FSEDGE 2'h3

// ==================================================================
// Operational mode codes
`define UPC_OPM_NORMAL     2'h0
`define UPC_OPM_NONDRIVE   2'h1
`define UPC_OPM_RAW        2'h2
`define UPC_OPM_RESERVED   2'h3

// ==================================================================
// Termination select levels
`define UPC_TERM_HS        1'h0
`define UPC_TERM_FS        1'h1

// ==================================================================
// Line condition bit positions
`define UPC_LINE_DP_BIT    0
`define UPC_LINE_DM_BIT    1

// ==================================================================
// Transmit state codes, one-hot
`define UPC_ST_IDLE        4'h1
`define UPC_ST_SYNC        4'h2
`define UPC_ST_DATA        4'h4
`define UPC_ST_EOP         4'h8

// ==================================================================
// Timing
`define UPC_RST_WAIT_EDGES 3'h5
`define UPC_SYS_CLK_KHZ    250000
`define UPC_IFCLK_KHZ      60000
`define UPC_HS_BIT_KHZ     480000
`define UPC_RX_MAX_HS_BITS 43
`define UPC_RX_MAX_CYCLES  ((`UPC_RX_MAX_HS_BITS * `UPC_SYS_CLK_KHZ) / `UPC_HS_BIT_KHZ)
`define UPC_ACC_W          18

// ==================================================================
// Transmit buffer
`define UPC_BUF_DEPTH      2
`define UPC_DATA_W         8

`endif

/* src/upc_phy_ctrl.v */
`timescale 1ns/100ps
`include "upc_defines.vh"

module upc_phy_ctrl (
  // Clock, reset, enable
  input  wire        clock,
  input  wire        nrst,
  input  wire        clk_en,
  // Configuration
  input  wire [1:0]  transceiver_speed_select,
  input  wire        termination_select,
  input  wire [1:0]  operational_mode_select,
  input  wire        low_power_suspend_n,
  input  wire        host_mode,
  // Transmit from link
  input  wire        tx_valid,
  input  wire [7:0]  tx_data,
  input  wire        tx_preamble,
  input  wire        tx_sof,
  input  wire        keepalive_req,
  output reg         tx_ready,
  // Receive to link
  output reg         rx_active,
  output reg         rx_valid,
  output reg  [7:0]  rx_data,
  // Line-side serializer
  input  wire        line_tx_ready,
  output reg         line_tx_valid,
  output reg  [7:0]  line_tx_data,
  output reg         line_tx_sync,
  output reg         line_tx_pre,
  output reg         line_tx_eop,
  output reg         line_tx_long_eop,
  output reg         line_keepalive,
  // Line-side deserializer
  input  wire        line_rx_sop,
  input  wire        line_rx_valid,
  input  wire [7:0]  line_rx_data,
  input  wire        line_rx_eop,
  input  wire        line_dp,
  input  wire        line_dm,
  input  wire        line_disconnect,
  // Analog controls
  output reg  [3:0]  speed_sel_onehot,
  output reg         hs_term_en,
  output reg         fs_term_en,
  output reg         pullup_en,
  output reg         pulldown_en,
  output reg         drive_en,
  output reg         stuff_nrzi_en,
  // Status
  output reg         downstream_detach_flag,
  output wire [1:0]  bus_line_condition,
  output reg         interface_clock_output
);

  // ================================================================
  // Helpers
  function [3:0] dec2;
    input [1:0] code;
    begin
      dec2 = 4'h1 << code;
    end
  endfunction

  localparam [`UPC_ACC_W-1:0] IFCLK_STEP = 2 * `UPC_IFCLK_KHZ;
  localparam [`UPC_ACC_W-1:0] IFCLK_MOD  = `UPC_SYS_CLK_KHZ;

  wire [3:0] xcvr_dec = dec2(transceiver_speed_select);
  wire [3:0] opm_dec  = dec2(operational_mode_select);
  wire       nondrive = opm_dec[`UPC_OPM_NONDRIVE];
  wire       is_hs    = xcvr_dec[`UPC_XCVR_HS];
  wire       is_ls    = xcvr_dec[`UPC_XCVR_LS] | xcvr_dec[`UPC_XCVR_LS_FSEDGE];
  wire       run      = clk_en & low_power_suspend_n;

  // ================================================================
  // State
  reg  [3:0]              state_q;
  reg  [3:0]              state_d;
  reg  [2:0]              boot_cnt_q;
  reg                     sof_q;
  reg  [1:0]              line_q;
  reg  [`UPC_ACC_W-1:0]   acc_q;
  wire                    buf_in_ready;
  wire                    buf_out_valid;
  wire [7:0]              buf_out_data;
  wire [1:0]              buf_level;
  wire                    push;
  wire                    pop;
  wire [2:0]              level_next;
  wire                    boot_done;
  wire [`UPC_ACC_W:0]     acc_sum;

  assign boot_done  = (boot_cnt_q == `UPC_RST_WAIT_EDGES);
  assign push       = tx_valid & tx_ready;
  assign pop        = buf_out_valid & (~line_tx_valid | line_tx_ready) &
                      state_q[2];
  assign level_next = {1'h0, buf_level} + {2'h0, push} - {2'h0, pop};
  // One bit wider, so the sum cannot wrap before the compare
  assign acc_sum    = {1'b0, acc_q} + {1'b0, IFCLK_STEP};

  // Combinational while suspended, clocked otherwise
  assign bus_line_condition = low_power_suspend_n ? line_q :
                              {line_dm, line_dp};

  upc_tx_buf u_buf (
    .clock     (clock),
    .nrst      (nrst),
    .clk_en    (run),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .in_data   (tx_data),
    .out_valid (buf_out_valid),
    .out_ready (pop),
    .out_data  (buf_out_data),
    .level     (buf_level)
  );

  // ================================================================
  // Transmit sequencer
  always @* begin
    state_d = state_q;
    case (state_q)
      `UPC_ST_IDLE: begin
        if (tx_valid & ~nondrive & boot_done)
          state_d = `UPC_ST_SYNC;
      end
      `UPC_ST_SYNC: begin
        if (line_tx_sync & line_tx_ready)
          state_d = `UPC_ST_DATA;
      end
      `UPC_ST_DATA: begin
        // Drain buffered bytes before closing the packet
        if (~tx_valid & ~buf_out_valid & ~line_tx_valid)
          state_d = `UPC_ST_EOP;
      end
      `UPC_ST_EOP: begin
        if (line_tx_eop & line_tx_ready)
          state_d = `UPC_ST_IDLE;
      end
      default: state_d = `UPC_ST_IDLE;
    endcase
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q          <= `UPC_ST_IDLE;
      boot_cnt_q       <= 3'h0;
      sof_q            <= 1'h0;
      tx_ready         <= 1'h0;
      line_tx_valid    <= 1'h0;
      line_tx_data     <= 8'h00;
      line_tx_sync     <= 1'h0;
      line_tx_pre      <= 1'h0;
      line_tx_eop      <= 1'h0;
      line_tx_long_eop <= 1'h0;
      line_keepalive   <= 1'h0;
    end else if (run) begin
      state_q <= state_d;
      // Holds off a too-early start from the link
      if (!boot_done)
        boot_cnt_q <= boot_cnt_q + 3'h1;
      // Only offer a slot the buffer is sure to have
      tx_ready <= (state_d == `UPC_ST_DATA) & (level_next < 3'h2) &
                  buf_in_ready;
      if (pop) begin
        line_tx_valid <= 1'h1;
        line_tx_data  <= buf_out_data;
      end else if (line_tx_ready) begin
        line_tx_valid <= 1'h0;
      end
      line_keepalive <= 1'h0;
      if (state_q[0] && state_d[1]) begin
        line_tx_sync <= 1'h1;
        line_tx_pre  <= tx_preamble & host_mode & is_ls;
        sof_q        <= tx_sof & is_hs;
      end else if (line_tx_ready) begin
        line_tx_sync <= 1'h0;
        line_tx_pre  <= 1'h0;
      end
      if (state_q[2] && state_d[3]) begin
        line_tx_eop      <= 1'h1;
        line_tx_long_eop <= sof_q;
      end else if (line_tx_ready) begin
        line_tx_eop      <= 1'h0;
        line_tx_long_eop <= 1'h0;
      end
      if (state_q[0] && state_d[0] && keepalive_req && is_ls && !nondrive)
        line_keepalive <= 1'h1;
    end
  end

  // ================================================================
  // Receive path, one cycle well inside the latency budget
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rx_active <= 1'h0;
      rx_valid  <= 1'h0;
      rx_data   <= 8'h00;
    end else if (run) begin
      // A new start in the end cycle keeps the flag up
      if (line_rx_sop)
        rx_active <= 1'h1;
      else if (line_rx_eop)
        rx_active <= 1'h0;
      rx_valid <= line_rx_valid & (rx_active | line_rx_sop);
      if (line_rx_valid)
        rx_data <= line_rx_data;
    end
  end

  // ================================================================
  // Analog controls; run on clk_en alone so suspend can act on them
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      speed_sel_onehot       <= 4'h0;
      hs_term_en             <= 1'h0;
      fs_term_en             <= 1'h0;
      pullup_en              <= 1'h0;
      pulldown_en            <= 1'h0;
      drive_en               <= 1'h0;
      stuff_nrzi_en          <= 1'h0;
      downstream_detach_flag <= 1'h0;
      line_q                 <= 2'h0;
    end else if (clk_en) begin
      speed_sel_onehot <= xcvr_dec;
      hs_term_en  <= ~nondrive & (termination_select == `UPC_TERM_HS);
      fs_term_en  <= ~nondrive & (termination_select == `UPC_TERM_FS);
      pullup_en   <= ~nondrive & (termination_select == `UPC_TERM_FS) &
                     ~(host_mode & ~low_power_suspend_n);
      pulldown_en <= ~nondrive & (host_mode | termination_select);
      drive_en      <= ~nondrive & low_power_suspend_n;
      stuff_nrzi_en <= ~opm_dec[`UPC_OPM_RAW];
      // Cleared on entering low power, whatever the detector says
      downstream_detach_flag <= line_disconnect & host_mode & is_hs &
                                low_power_suspend_n;
      line_q[`UPC_LINE_DP_BIT] <= line_dp;
      line_q[`UPC_LINE_DM_BIT] <= line_dm;
    end
  end

  // ================================================================
  // Reference clock; fractional divider, so edges jitter by one cycle
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      acc_q                  <= {`UPC_ACC_W{1'b0}};
      interface_clock_output <= 1'h0;
    end else if (run) begin
      if (acc_sum >= {1'b0, IFCLK_MOD}) begin
        acc_q <= acc_sum[`UPC_ACC_W-1:0] - IFCLK_MOD;
        interface_clock_output <= ~interface_clock_output;
      end else begin
        acc_q <= acc_sum[`UPC_ACC_W-1:0];
      end
    end
  end

endmodule // upc_phy_ctrl

/* src/upc_tx_buf.v */
`timescale 1ns/100ps
`include "upc_defines.vh"

module upc_tx_buf (
  // Clock and reset
  input  wire                    clock,
  input  wire                    nrst,
  input  wire                    clk_en,
  // Fill side
  input  wire                    in_valid,
  output wire                    in_ready,
  input  wire [`UPC_DATA_W-1:0]  in_data,
  // Drain side
  output wire                    out_valid,
  input  wire                    out_ready,
  output wire [`UPC_DATA_W-1:0]  out_data,
  // Fill level
  output wire [1:0]              level
);

  reg [`UPC_DATA_W-1:0] mem_q [0:`UPC_BUF_DEPTH-1];
  reg                   wr_ptr_q;
  reg                   rd_ptr_q;
  reg [1:0]             count_q;
  wire                  push;
  wire                  pop;

  assign in_ready  = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data  = mem_q[rd_ptr_q];
  assign level     = count_q;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_q <= 1'h0;
      rd_ptr_q <= 1'h0;
      count_q  <= 2'h0;
      mem_q[0] <= 8'h00;
      mem_q[1] <= 8'h00;
    end else if (clk_en) begin
      if (push) begin
        mem_q[wr_ptr_q] <= in_data;
        wr_ptr_q        <= ~wr_ptr_q;
      end
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      case ({push, pop})
        2'h2:    count_q <= count_q + 2'h1;
        2'h1:    count_q <= count_q - 2'h1;
        default: count_q <= count_q;
      endcase
    end
  end

endmodule // upc_tx_buf

/* test/tb.sv */
`timescale 1ns/100ps
module tb;
  // ==========
  // Signals
  logic clock = 0, nrst = 0, clk_en = 1, go = 0, slow = 0;
  logic [1:0] transceiver_speed_select = 2'h1, operational_mode_select = 2'h0;
  logic termination_select = 1, low_power_suspend_n = 1, host_mode = 1;
  logic tx_preamble = 0, tx_sof = 0, keepalive_req = 0, line_tx_ready = 0;
  logic line_rx_sop = 0, line_rx_valid = 0, line_rx_eop = 0;
  logic line_dp = 1, line_dm = 0, line_disconnect = 0;
  logic [7:0] line_rx_data = 8'h00, len = 8'h01, exp_q = 8'h00, cyc = 8'h00;
  logic [3:0] eop_n = 4'h0;
  logic sync_q = 0, pre_q = 0, long_q = 0, ka_q = 0;
  logic [7:0] ck_n = 8'h00, c0 = 8'h00;
  logic ck_last = 0;
  wire tx_valid, tx_ready, rx_active, rx_valid, line_tx_valid, line_tx_sync;
  wire line_tx_pre, line_tx_eop, line_tx_long_eop, line_keepalive, drive_en;
  wire stuff_nrzi_en, downstream_detach_flag, hs_term_en, fs_term_en;
  wire pullup_en, pulldown_en, interface_clock_output;
  wire [7:0] tx_data, rx_data, line_tx_data;
  wire [3:0] speed_sel_onehot;
  wire [1:0] bus_line_condition;
  int err_count = 0, total_checks = 0, k;

  always #2 clock = ~clock;

  upc_phy_ctrl upc_phy_ctrl_inst (.clock, .nrst, .clk_en,
    .transceiver_speed_select, .termination_select, .operational_mode_select,
    .low_power_suspend_n, .host_mode, .tx_valid, .tx_data, .tx_preamble,
    .tx_sof, .keepalive_req, .tx_ready, .rx_active, .rx_valid, .rx_data,
    .line_tx_ready, .line_tx_valid, .line_tx_data, .line_tx_sync,
    .line_tx_pre, .line_tx_eop, .line_tx_long_eop, .line_keepalive,
    .line_rx_sop, .line_rx_valid, .line_rx_data, .line_rx_eop, .line_dp,
    .line_dm, .line_disconnect, .speed_sel_onehot, .hs_term_en, .fs_term_en,
    .pullup_en, .pulldown_en, .drive_en, .stuff_nrzi_en,
    .downstream_detach_flag, .bus_line_condition, .interface_clock_output);

  upc_link_model upc_link_model_inst (.clock, .nrst, .go, .len, .tx_ready,
    .tx_valid, .tx_data);

  task automatic check(string name, logic [7:0] seen, logic [7:0] expd);
    total_checks++;
    if (seen !== expd) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, expd, seen);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ==========
  // Serializer stand-in, stalls three cycles in four when slow
  always @(posedge clock) begin
    cyc <= cyc + 8'h01;
    line_tx_ready <= slow ? (cyc[1:0] == 2'h0) : 1'b1;
    pre_q <= pre_q | line_tx_pre;
    long_q <= long_q | line_tx_long_eop;
    ka_q <= ka_q | line_keepalive;
    if (!nrst) begin
      exp_q <= 8'h00;
      sync_q <= 1'b0;
    end else begin
      if (line_tx_sync && line_tx_ready) sync_q <= 1'b1;
      if (line_tx_eop && line_tx_ready) begin
        sync_q <= 1'b0;
        eop_n <= eop_n + 4'h1;
      end
      if (line_tx_valid && line_tx_ready) begin
        check("line byte", line_tx_data, exp_q);
        check("sync first", {7'h00, sync_q}, 8'h01);
        exp_q <= exp_q + 8'h01;
      end
    end
  end

  // Counts edges of the reference clock output
  always @(posedge clock) begin
    ck_last <= interface_clock_output;
    if (interface_clock_output != ck_last) ck_n <= ck_n + 8'h01;
  end

  task automatic send(input logic [7:0] n);
    logic [3:0] e0;
    logic [7:0] b0;
    e0 = eop_n;
    b0 = exp_q;
    len <= n;
    go <= 1'b1;
    for (k = 0; k < 400 && eop_n == e0; k++) begin
      @(posedge clock);
      if (tx_valid) go <= 1'b0;
    end
    if (eop_n == e0) begin
      check("packet end", 8'h00, 8'h01);
      print_verdict;
    end
    check("byte count", exp_q - b0, n);
  endtask

  task automatic rx_pkt(input logic [7:0] d0);
    line_rx_sop <= 1'b1;
    line_rx_valid <= 1'b1;
    line_rx_data <= d0;
    @(posedge clock);
    line_rx_sop <= 1'b0;
    line_rx_data <= d0 + 8'h01;
    @(posedge clock);
    check("rx start", rx_active, 1);
    check("rx byte", rx_data, d0);
    check("rx valid", rx_valid, 1);
    line_rx_valid <= 1'b0;
    line_rx_eop <= 1'b1;
    @(posedge clock);
    check("rx byte2", rx_data, d0 + 8'h01);
    line_rx_eop <= 1'b0;
    line_rx_valid <= 1'b1;
    @(posedge clock);
    check("rx end", rx_active, 0);
    line_rx_valid <= 1'b0;
    @(posedge clock);
    check("rx stray", rx_valid, 0);
  endtask

  // ==========
  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      transceiver_speed_select <= i[1:0];
      termination_select <= i[0];
      operational_mode_select <= (i == 3) ? 2'h0 : i[1:0];
      repeat (2) @(posedge clock);
      check("speed", speed_sel_onehot, 4'h1 << i);
      check("hs term", hs_term_en, i != 1 && !i[0]);
      check("fs term", fs_term_en, i == 3);
      check("stuff", stuff_nrzi_en, i != 2);
    end
    // 25 running edges of 120000 steps mod 250000 give 12 toggles
    c0 = ck_n;
    repeat (25) @(posedge clock);
    check("ifclk", ck_n - c0, 8'h0C);
    clk_en <= 1'b0;
    transceiver_speed_select <= 2'h1;
    repeat (3) @(posedge clock);
    check("frozen", speed_sel_onehot, 4'h8);
    clk_en <= 1'b1;
    transceiver_speed_select <= 2'h1;
    send(8'h05);
    slow <= 1'b1;
    send(8'h08);
    slow <= 1'b0;
    rx_pkt(8'hA5);
    transceiver_speed_select <= 2'h0;
    line_disconnect <= 1'b1;
    repeat (3) @(posedge clock);
    check("detach", downstream_detach_flag, 1);
    check("pull-up on", pullup_en, 1);
    low_power_suspend_n <= 1'b0;
    line_dp <= 1'b0;
    line_dm <= 1'b1;
    repeat (2) @(posedge clock);
    check("detach clr", downstream_detach_flag, 0);
    check("pull-up", pullup_en, 0);
    check("line susp", bus_line_condition, 2'h2);
    check("pull-down", pulldown_en, 1);
    check("drive off", drive_en, 0);
    c0 = ck_n;
    repeat (3) @(posedge clock);
    check("clk stop", ck_n - c0, 8'h00);
    low_power_suspend_n <= 1'b1;
    line_disconnect <= 1'b0;
    line_dp <= 1'b1;
    line_dm <= 1'b0;
    repeat (3) @(posedge clock);
    check("line run", bus_line_condition, 2'h1);
    transceiver_speed_select <= 2'h2;
    tx_preamble <= 1'b1;
    send(8'h02);
    check("preamble", pre_q, 1);
    tx_preamble <= 1'b0;
    keepalive_req <= 1'b1;
    repeat (4) @(posedge clock);
    keepalive_req <= 1'b0;
    check("keepalive", ka_q, 1);
    transceiver_speed_select <= 2'h0;
    tx_sof <= 1'b1;
    send(8'h01);
    check("long eop", long_q, 1);
    tx_sof <= 1'b0;
    // Reset in mid-packet
    go <= 1'b1;
    repeat (12) @(posedge clock);
    nrst <= 1'b0;
    go <= 1'b0;
    @(posedge clock);
    check("rst ready", tx_ready, 0);
    check("rst line", line_tx_sync | line_tx_valid, 0);
    // Reset held one more edge; the bench byte counter already cleared on the first
    @(posedge clock);
    nrst <= 1'b1;
    send(8'h03);
    print_verdict;
  end
endmodule // tb

/* test/upc_link_model.sv */
`timescale 1ns/100ps
// ==========
// Link transmit model
module upc_link_model (
  // Clock and reset
  input  wire       clock,
  input  wire       nrst,
  // Bench control
  input  wire       go,
  input  wire [7:0] len,
  // Transmit handshake
  input  wire       tx_ready,
  output reg        tx_valid,
  output reg  [7:0] tx_data
);
  reg [7:0] left_q;
  reg [2:0] boot_q;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      left_q <= 8'h00;
      boot_q <= 3'h0;
    end else begin
      if (boot_q != 3'h5) boot_q <= boot_q + 3'h1;
      if (go && !tx_valid && boot_q == 3'h5) begin
        tx_valid <= 1'b1;
        left_q <= len;
      end else if (tx_valid && tx_ready) begin
        tx_data <= tx_data + 8'h01;
        left_q <= left_q - 8'h01;
        if (left_q == 8'h01) tx_valid <= 1'b0;
      end
    end
  end
endmodule // upc_link_model

/* test/upc_phy_ctrl_sva.sv */
`timescale 1ns/100ps
// ==========
// Port checks
module upc_phy_ctrl_sva (
  // Clock and reset
  input wire       clock,
  input wire       nrst,
  input wire       clk_en,
  // Inputs
  input wire [1:0] transceiver_speed_select,
  input wire       termination_select,
  input wire [1:0] operational_mode_select,
  input wire       low_power_suspend_n,
  input wire       host_mode,
  input wire       tx_valid,
  input wire       line_rx_sop,
  input wire       line_rx_valid,
  input wire [7:0] line_rx_data,
  input wire       line_rx_eop,
  input wire       line_dp,
  input wire       line_dm,
  // Outputs
  input wire       rx_active,
  input wire       rx_valid,
  input wire [7:0] rx_data,
  input wire       line_tx_sync,
  input wire       line_tx_eop,
  input wire [3:0] speed_sel_onehot,
  input wire       hs_term_en,
  input wire       fs_term_en,
  input wire       pullup_en,
  input wire       downstream_detach_flag,
  input wire [1:0] bus_line_condition
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  wire run = clk_en && low_power_suspend_n;
  wire idl = !low_power_suspend_n;

  a_speed_onehot: assert property (
    clk_en |=> speed_sel_onehot == (4'h1 << $past(transceiver_speed_select)))
    else $error("speed one-hot wrong");
  a_term_pick: assert property (
    clk_en && operational_mode_select == 2'h0 |=>
      hs_term_en != $past(termination_select) &&
      fs_term_en == $past(termination_select))
    else $error("termination wrong");
  a_nondrive_off: assert property (
    clk_en && operational_mode_select == 2'h1 |=>
      !hs_term_en && !fs_term_en && !pullup_en)
    else $error("terminations left on");
  a_pullup_drop: assert property (
    clk_en && host_mode && idl |=> !pullup_en)
    else $error("pull-up kept in suspend");
  a_detach_clear: assert property (
    clk_en && idl |=> !downstream_detach_flag)
    else $error("detach flag kept in suspend");
  a_line_comb: assert property (
    idl |-> bus_line_condition == {line_dm, line_dp})
    else $error("line condition not direct");
  a_sync_cause: assert property (
    $rose(line_tx_sync) |-> $past(tx_valid))
    else $error("sync without valid");
  a_eop_cause: assert property (
    $rose(line_tx_eop) |-> !$past(tx_valid))
    else $error("eop while valid");
  a_rx_start: assert property (
    run && line_rx_sop |=> rx_active)
    else $error("receive not active");
  a_rx_end: assert property (
    run && line_rx_eop && !line_rx_sop |=> !rx_active)
    else $error("receive still active");
  a_rx_byte: assert property (
    run && line_rx_valid && (rx_active || line_rx_sop) |=>
      rx_valid && rx_data == $past(line_rx_data))
    else $error("receive byte late or wrong");

  c_rx: cover property (run && line_rx_sop);
  c_eop: cover property ($rose(line_tx_eop));
  c_susp: cover property (idl && host_mode);
endmodule // upc_phy_ctrl_sva

bind upc_phy_ctrl upc_phy_ctrl_sva upc_phy_ctrl_sva_inst (
  .clock, .nrst, .clk_en, .transceiver_speed_select, .termination_select,
  .operational_mode_select, .low_power_suspend_n, .host_mode, .tx_valid,
  .line_rx_sop, .line_rx_valid, .line_rx_data, .line_rx_eop, .line_dp,
  .line_dm, .rx_active, .rx_valid, .rx_data, .line_tx_sync, .line_tx_eop,
  .speed_sel_onehot, .hs_term_en, .fs_term_en, .pullup_en,
  .downstream_detach_flag, .bus_line_condition);
